// >>> ddr_burst2_sram_port_with_ecc_test.sv
`timescale 1ns/1ps
module ddr_burst2_sram_port_with_ecc_test;
    localparam logic [35:0] D1 = 36'h1_2345_6789;
    localparam logic [35:0] D2 = 36'hf_edcb_a987;
    localparam logic [35:0] LANE1 = 36'hf_f803_fe00;
    localparam logic [35:0] MIX = (D1 & LANE1) | (D2 & ~LANE1);
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_read = 1'b0;
    logic freq_change = 1'b0;
    logic inject_valid = 1'b0;
    logic [5:0] req_addr = 6'h00;
    logic [5:0] inject_addr = 6'h00;
    logic [5:0] inject_bit = 6'h00;
    logic [35:0] req_wdata = 36'h0_0000_0000;
    logic [3:0] req_ben_n = 4'hf;
    logic req_ready, ops_ready, rsp_valid, dll_locked, ecc_active, corrected;
    logic [35:0] rsp_rdata;
    logic corr_seen = 1'b0;
    int miscompares = 0;
    int total_checks = 0;
    sram_link_if sram_link_if_i ();
    // Short power-up counts keep the run brief; the ordering is unchanged.
    sram_dev_end #(.LOCK_KCYC(8)) sram_dev_end_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .link(sram_link_if_i.dev), .inject_valid(inject_valid), .inject_addr(inject_addr),
        .inject_bit(inject_bit), .dll_locked(dll_locked), .ecc_active(ecc_active),
        .corrected(corrected));
    sram_ctl_end #(.IMPED_KCYC(8), .LOCK_KCYC(8)) sram_ctl_end_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .link(sram_link_if_i.ctl), .req_valid(req_valid),
        .req_ready(req_ready), .req_read(req_read), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ben_n(req_ben_n), .freq_change(freq_change),
        .ops_ready(ops_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    sram_link_props sram_link_props_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .k_true(sram_link_if_i.k_true), .load_strobe_n(sram_link_if_i.load_strobe_n),
        .rw_read(sram_link_if_i.rw_read),
        .byte_write_enables_n(sram_link_if_i.byte_write_enables_n),
        .ctl_dq_oe(sram_link_if_i.ctl_dq_oe), .dev_dq_oe(sram_link_if_i.dev_dq_oe),
        .echo_clock_out(sram_link_if_i.echo_clock_out),
        .read_valid_out(sram_link_if_i.read_valid_out));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (corrected === 1'b1) corr_seen <= 1'b1;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic push(input logic rd, input logic [5:0] a, input logic [35:0] d,
                        input logic [3:0] b);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_read <= rd;
        req_addr <= a;
        req_wdata <= d;
        req_ben_n <= b;
        @(posedge clk_sys);
        req_valid <= 1'b0;
    endtask
    task automatic inject(input logic [5:0] a, input logic [5:0] b);
        @(posedge clk_sys);
        inject_valid <= 1'b1;
        inject_addr <= a;
        inject_bit <= b;
        @(posedge clk_sys);
        inject_valid <= 1'b0;
    endtask
    task automatic await_rsp(input logic [35:0] exp, input string msg);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (rsp_valid !== 1'b1 && n < 200);
        if (rsp_valid !== 1'b1) begin
            miscompares++;
            close_out();
        end else begin
            check(rsp_rdata, exp, msg);
        end
    endtask
    task automatic await_ops(input logic lvl);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (ops_ready !== lvl && n < 400);
        if (ops_ready !== lvl) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic t_power_up();
        await_ops(1'b1);
        check({34'h0, dll_locked, ecc_active}, 36'h0_0000_0003, "power-up");
        check({35'h0, req_ready}, 36'h0_0000_0001, "request port not ready");
        $display("power-up done");
    endtask
    task automatic t_mask_write();
        push(1'b0, 6'h01, D1, 4'h0);
        push(1'b0, 6'h01, D2, 4'ha);
        push(1'b1, 6'h01, D1, 4'hf);
        push(1'b1, 6'h01, D1, 4'hf);
        await_rsp(MIX, "masked lane");
        await_rsp(MIX, "second read");
        $display("mask write done");
    endtask
    task automatic t_ecc_fix();
        corr_seen = 1'b0;
        inject(6'h01, 6'h04);
        push(1'b1, 6'h01, D1, 4'hf);
        await_rsp(MIX, "single error fixed");
        check({35'h0, corr_seen}, 36'h0_0000_0001, "no correction flag");
        $display("ecc fix done");
    endtask
    task automatic t_half_write();
        push(1'b0, 6'h02, 36'h0_0000_0155, 4'he);
        push(1'b1, 6'h02, D1, 4'hf);
        await_rsp(36'h0_0000_0155, "half write data");
        check({35'h0, ecc_active}, 36'h0_0000_0000, "ecc still on");
        corr_seen = 1'b0;
        inject(6'h02, 6'h02);
        push(1'b1, 6'h02, D1, 4'hf);
        await_rsp(36'h0_0000_0154, "raw data expected");
        check({35'h0, corr_seen}, 36'h0_0000_0000, "correction while off");
        $display("half write done");
    endtask
    task automatic t_freq_change();
        @(posedge clk_sys);
        freq_change <= 1'b1;
        @(posedge clk_sys);
        freq_change <= 1'b0;
        await_ops(1'b0);
        repeat (2) @(posedge clk_sys);
        #1;
        check({35'h0, dll_locked}, 36'h0_0000_0000, "loop still locked");
        await_ops(1'b1);
        check({35'h0, dll_locked}, 36'h0_0000_0001, "loop not relocked");
        $display("freq change done");
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_power_up();
        t_mask_write();
        t_ecc_fix();
        t_half_write();
        t_freq_change();
        close_out();
    end
endmodule // ddr_burst2_sram_port_with_ecc_test

// >>> sram_ctl_end.sv
`timescale 1ns/1ps
module sram_req_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // DEPTH must be a power of two so the pointers wrap by themselves.
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic full_q;
    logic empty_q;

    wire push = in_valid && !full_q;
    wire pop = out_ready && !empty_q;
    wire [AW:0] cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_d;
            full_q <= cnt_d == (AW+1)'(DEPTH);
            empty_q <= cnt_d == '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready = !full_q;
    assign out_valid = !empty_q;
    assign out_data = mem_q[rd_q];

endmodule // sram_req_fifo

module sram_ctl_end #(
    parameter int LANES = 2,
    parameter int ADDR_W = 6,
    parameter int FIFO_DEPTH = 16,
    parameter int IMPED_KCYC = sram_pkg::IMPED_KCYC,
    parameter int LOCK_KCYC = sram_pkg::LOCK_KCYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    sram_link_if.ctl link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_read,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [2*LANES*sram_pkg::LANE_BITS-1:0] req_wdata,
    input wire logic [2*LANES-1:0] req_ben_n,
    input wire logic freq_change,
    output logic ops_ready,
    output logic rsp_valid,
    output logic [2*LANES*sram_pkg::LANE_BITS-1:0] rsp_rdata
);
    localparam int DW = LANES * sram_pkg::LANE_BITS;
    localparam int WD = 2 * DW + 2 * LANES;
    localparam int FW = 1 + ADDR_W + WD;
    localparam int KMAX = IMPED_KCYC > LOCK_KCYC ? IMPED_KCYC : LOCK_KCYC;
    localparam int KW = $clog2(KMAX + 1);

    sram_pkg::pwr_t state_q;
    sram_pkg::pwr_t state_d;
    logic [KW-1:0] kc_q;
    logic k_q;
    logic dll_q;
    logic run_q;
    logic load_n_q;
    logic rw_q;
    logic [ADDR_W-1:0] addr_q;
    logic [1:0] rd_block_q;
    logic wv_q [3];
    logic [WD-1:0] wd_q [3];
    logic [DW-1:0] dq_q;
    logic oe_q;
    logic [LANES-1:0] ben_q;
    logic beat_q;
    logic [DW-1:0] lo_q;
    logic rsp_valid_q;
    logic [2*DW-1:0] rsp_q;
    logic f_valid;
    logic [FW-1:0] f_data;

    wire head_rd = f_data[FW-1];
    wire [ADDR_W-1:0] head_addr = f_data[WD +: ADDR_W];
    wire decide = !k_q && state_q == sram_pkg::PWR_RUN;
    // A write waits until the last read's beats have left the bus.
    wire issue_rd = decide && f_valid && head_rd;
    wire issue_wr = decide && f_valid && !head_rd && rd_block_q == 2'h0;
    wire issue = issue_rd || issue_wr;
    wire [KW-1:0] limit = state_q == sram_pkg::PWR_IMPED ? KW'(IMPED_KCYC - 1) :
                          state_q == sram_pkg::PWR_LOCK ? KW'(LOCK_KCYC - 1) :
                          KW'(sram_pkg::DLL_RESET_KCYC - 1);
    wire k_done = k_q && kc_q == limit;

    sram_req_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) sram_req_fifo_i (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_read, req_addr, req_ben_n, req_wdata}),
        .out_valid(f_valid),
        .out_ready(issue),
        .out_data(f_data)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            sram_pkg::PWR_IMPED: state_d = k_done ? sram_pkg::PWR_LOCK : state_q;
            sram_pkg::PWR_LOCK: state_d = freq_change ? sram_pkg::PWR_DLL_RST :
                                          (k_done ? sram_pkg::PWR_RUN : state_q);
            sram_pkg::PWR_RUN: state_d = freq_change ? sram_pkg::PWR_DLL_RST : state_q;
            sram_pkg::PWR_DLL_RST: state_d = k_done ? sram_pkg::PWR_LOCK : state_q;
            default: state_d = sram_pkg::PWR_IMPED;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= sram_pkg::PWR_IMPED;
            kc_q <= '0;
            k_q <= 1'b0;
            dll_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            state_q <= state_d;
            k_q <= !k_q;
            kc_q <= (state_d != state_q) ? '0 : (k_q ? kc_q + 1'b1 : kc_q);
            dll_q <= state_d == sram_pkg::PWR_LOCK || state_d == sram_pkg::PWR_RUN;
            run_q <= state_d == sram_pkg::PWR_RUN;
        end
    end

    // Commands are set up the half-cycle before the true edge that samples them.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            load_n_q <= 1'b1;
            rw_q <= 1'b1;
            addr_q <= '0;
            rd_block_q <= 2'h0;
        end else begin
            load_n_q <= !issue;
            rw_q <= issue ? head_rd : rw_q;
            addr_q <= issue ? head_addr : addr_q;
            if (issue_rd) begin
                rd_block_q <= 2'(sram_pkg::RD_SPACING_K);
            end else if (decide && rd_block_q != 2'h0) begin
                rd_block_q <= rd_block_q - 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wv_q[0] <= 1'b0;
            wd_q[0] <= '0;
        end else begin
            wv_q[0] <= issue_wr;
            wd_q[0] <= f_data[WD-1:0];
        end
    end

    for (genvar s = 1; s < 3; s++) begin : g_wpipe
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                wv_q[s] <= 1'b0;
                wd_q[s] <= '0;
            end else begin
                wv_q[s] <= wv_q[s-1];
                wd_q[s] <= wd_q[s-1];
            end
        end
    end

    // Beat one on the true edge after the command, beat two half a cycle later.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dq_q <= '0;
            oe_q <= 1'b0;
            ben_q <= '1;
        end else if (wv_q[1]) begin
            dq_q <= wd_q[1][DW-1:0];
            oe_q <= 1'b1;
            ben_q <= wd_q[1][2*DW +: LANES];
        end else if (wv_q[2]) begin
            dq_q <= wd_q[2][DW +: DW];
            oe_q <= 1'b1;
            ben_q <= wd_q[2][2*DW+LANES +: LANES];
        end else begin
            dq_q <= '0;
            oe_q <= 1'b0;
            ben_q <= '1;
        end
    end

    // Valid read beats pair up in order: first beat low half, second high half.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            beat_q <= 1'b0;
            lo_q <= '0;
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
        end else begin
            beat_q <= link.read_valid_out && !beat_q;
            lo_q <= (link.read_valid_out && !beat_q) ? link.dq_bus : lo_q;
            rsp_valid_q <= link.read_valid_out && beat_q;
            rsp_q <= (link.read_valid_out && beat_q) ? {link.dq_bus, lo_q} : rsp_q;
        end
    end

    assign link.k_true = k_q;
    assign link.load_strobe_n = load_n_q;
    assign link.rw_read = rw_q;
    assign link.sync_address_inputs = addr_q;
    assign link.byte_write_enables_n = ben_q;
    assign link.dll_off_n = dll_q;
    assign link.ctl_dq = dq_q;
    assign link.ctl_dq_oe = oe_q;
    assign ops_ready = run_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rsp_q;

endmodule // sram_ctl_end

// >>> sram_dev_end.sv
`timescale 1ns/1ps
module sram_dev_end #(
    parameter int LANES = 2,
    parameter int ADDR_W = 6,
    parameter int LOCK_KCYC = sram_pkg::LOCK_KCYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    sram_link_if.dev link,
    input wire logic inject_valid,
    input wire logic [ADDR_W-1:0] inject_addr,
    input wire logic [$clog2(LANES*sram_pkg::CW_BITS)-1:0] inject_bit,
    output logic dll_locked,
    output logic ecc_active,
    output logic corrected
);
    localparam int LB = sram_pkg::LANE_BITS;
    localparam int WB = sram_pkg::WORD_BITS;
    localparam int CW = sram_pkg::CW_BITS;
    localparam int DW = LANES * LB;
    localparam int RW = LANES * CW;
    localparam int DEPTH = 2 ** ADDR_W;
    localparam int PL = sram_pkg::PIPE_LEN;
    localparam int SW = 8;
    localparam int LCW = $clog2(LOCK_KCYC + 1);

    sram_pkg::cmd_t cmd_in;
    sram_pkg::cmd_t pipe_q [PL];
    logic [ADDR_W-1:0] paddr_q [PL];
    logic [RW-1:0] mem_q [DEPTH];
    logic [DW-1:0] b1_dq_q;
    logic [LANES-1:0] b1_ben_n_q;
    logic [DW-1:0] rbeat2_q;
    logic [DW-1:0] dq_q;
    logic oe_q;
    logic valid_q;
    logic echo_q;
    logic ecc_on_q;
    logic corrected_q;
    logic k_prev_q;
    logic [SW-1:0] stop_q;
    logic [LCW-1:0] lock_q;
    logic locked_q;

    logic [RW-1:0] wr_row_d;
    logic [LANES-1:0] half_w;
    logic [DW-1:0] rd_lo;
    logic [DW-1:0] rd_hi;
    logic [LANES-1:0] rd_fix;

    // A command exists only in a true-edge cycle with the load strobe low.
    assign cmd_in = (!link.k_true || link.load_strobe_n) ? sram_pkg::CMD_NONE :
                    (link.rw_read ? sram_pkg::CMD_READ : sram_pkg::CMD_WRITE);

    wire [ADDR_W-1:0] wr_addr = paddr_q[sram_pkg::ST_WR_BEAT2];
    wire [ADDR_W-1:0] rd_addr = paddr_q[sram_pkg::ST_RD_FETCH];
    wire b1_take = pipe_q[sram_pkg::ST_WR_BEAT1] == sram_pkg::CMD_WRITE;
    wire wr_commit = pipe_q[sram_pkg::ST_WR_BEAT2] == sram_pkg::CMD_WRITE;
    wire rd_now = pipe_q[sram_pkg::ST_RD_FETCH] == sram_pkg::CMD_READ;
    wire rd_b2 = pipe_q[sram_pkg::ST_RD_BEAT2] == sram_pkg::CMD_READ;
    wire k_stopped = stop_q >= SW'(sram_pkg::KSTOP_CYC);

    // Every accepted command walks the whole pipeline; nothing can cut it short.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pipe_q[0] <= sram_pkg::CMD_NONE;
            paddr_q[0] <= '0;
        end else begin
            pipe_q[0] <= cmd_in;
            paddr_q[0] <= link.sync_address_inputs;
        end
    end

    for (genvar s = 1; s < PL; s++) begin : g_pipe
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                pipe_q[s] <= sram_pkg::CMD_NONE;
                paddr_q[s] <= '0;
            end else begin
                pipe_q[s] <= pipe_q[s-1];
                paddr_q[s] <= paddr_q[s-1];
            end
        end
    end

    // Each lane keeps one 23-bit codeword per address: two 9-bit beats plus parity.
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        wire [CW-1:0] old_cw = mem_q[wr_addr][l*CW +: CW];
        wire [WB-1:0] old_d = sram_pkg::ecc_correct(old_cw, ecc_on_q);
        wire keep1 = b1_ben_n_q[l];
        wire keep2 = link.byte_write_enables_n[l];
        wire [LB-1:0] new_lo = keep1 ? old_d[LB-1:0] : b1_dq_q[l*LB +: LB];
        wire [LB-1:0] new_hi = keep2 ? old_d[WB-1:LB] : link.dq_bus[l*LB +: LB];
        wire [CW-1:0] rd_cw = mem_q[rd_addr][l*CW +: CW];
        wire [WB-1:0] rd_d = sram_pkg::ecc_correct(rd_cw, ecc_on_q);

        // An aborted lane keeps its codeword bit for bit.
        assign wr_row_d[l*CW +: CW] = (keep1 && keep2) ? old_cw :
                                      sram_pkg::ecc_encode({new_hi, new_lo});
        assign half_w[l] = keep1 ^ keep2;
        assign rd_lo[l*LB +: LB] = rd_d[LB-1:0];
        assign rd_hi[l*LB +: LB] = rd_d[WB-1:LB];
        assign rd_fix[l] = ecc_on_q && (sram_pkg::ecc_syndrome(rd_cw) != '0);
    end

    // First write beat and its enables are held until the second beat arrives.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            b1_dq_q <= '0;
            b1_ben_n_q <= '1;
        end else if (b1_take) begin
            b1_dq_q <= link.dq_bus;
            b1_ben_n_q <= link.byte_write_enables_n;
        end
    end

    // The commit lands before any later read fetch of the same address,
    // so reads after writes see the new data. A commit beats an injection.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int a = 0; a < DEPTH; a++) begin
                mem_q[a] <= '0;
            end
        end else if (wr_commit) begin
            mem_q[wr_addr] <= wr_row_d;
        end else if (inject_valid) begin
            mem_q[inject_addr][inject_bit] <= ~mem_q[inject_addr][inject_bit];
        end
    end

    // Only reset stands in for power removal here.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ecc_on_q <= 1'b1;
        end else if (wr_commit && (|half_w)) begin
            ecc_on_q <= 1'b0;
        end
    end

    // Read data drives the pins 2.5 input clocks after the command; any other
    // command leaves the drivers off for the same two half-cycles.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dq_q <= '0;
            oe_q <= 1'b0;
            valid_q <= 1'b0;
            rbeat2_q <= '0;
            corrected_q <= 1'b0;
        end else begin
            dq_q <= rd_now ? rd_lo : (rd_b2 ? rbeat2_q : '0);
            oe_q <= rd_now || rd_b2;
            valid_q <= rd_now || rd_b2;
            rbeat2_q <= rd_now ? rd_hi : rbeat2_q;
            corrected_q <= rd_now && (|rd_fix);
        end
    end

    // The loop counts true edges of clean clock; a flat clock for the stop
    // time or a low disable input throws the lock away.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            k_prev_q <= 1'b0;
            stop_q <= '0;
        end else begin
            k_prev_q <= link.k_true;
            if (link.k_true != k_prev_q) begin
                stop_q <= '0;
            end else if (!k_stopped) begin
                stop_q <= stop_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lock_q <= '0;
            locked_q <= 1'b0;
        end else if (!link.dll_off_n || k_stopped) begin
            lock_q <= '0;
            locked_q <= 1'b0;
        end else if (link.k_true && !locked_q) begin
            lock_q <= lock_q + 1'b1;
            locked_q <= lock_q == LCW'(LOCK_KCYC - 1);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            echo_q <= 1'b0;
        end else begin
            echo_q <= link.k_true;
        end
    end

    assign link.dev_dq = dq_q;
    assign link.dev_dq_oe = oe_q;
    assign link.read_valid_out = valid_q;
    assign link.echo_clock_out = echo_q;
    assign dll_locked = locked_q;
    assign ecc_active = ecc_on_q;
    assign corrected = corrected_q;

endmodule // sram_dev_end

// >>> sram_link_if.sv
`timescale 1ns/1ps
interface sram_link_if #(
    parameter int LANES = 2,
    parameter int ADDR_W = 6
);
    localparam int DW = LANES * sram_pkg::LANE_BITS;

    logic k_true;
    logic load_strobe_n;
    logic rw_read;
    logic [ADDR_W-1:0] sync_address_inputs;
    logic [LANES-1:0] byte_write_enables_n;
    logic dll_off_n;
    logic [DW-1:0] ctl_dq;
    logic ctl_dq_oe;
    logic [DW-1:0] dev_dq;
    logic dev_dq_oe;
    logic [DW-1:0] dq_bus;
    logic echo_clock_out;
    logic read_valid_out;

    // Resolved data pins; an undriven bus reads as zero.
    assign dq_bus = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);

    modport dev (
        input k_true, load_strobe_n, rw_read, sync_address_inputs, byte_write_enables_n,
        input dll_off_n, dq_bus,
        output dev_dq, dev_dq_oe, echo_clock_out, read_valid_out
    );

    modport ctl (
        output k_true, load_strobe_n, rw_read, sync_address_inputs, byte_write_enables_n,
        output dll_off_n, ctl_dq, ctl_dq_oe,
        input dq_bus, echo_clock_out, read_valid_out
    );
endinterface

// >>> sram_link_props.sv
`timescale 1ns/1ps
module sram_link_props (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic k_true,
    input wire logic load_strobe_n,
    input wire logic rw_read,
    input wire logic [1:0] byte_write_enables_n,
    input wire logic ctl_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic echo_clock_out,
    input wire logic read_valid_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire rd_cmd = !load_strobe_n && rw_read;
    wire wr_cmd = !load_strobe_n && !rw_read;
    a_cmd_true_slot: assert property (!load_strobe_n |-> k_true)
        else $error("command outside a true slot");
    a_read_two_beats: assert property (rd_cmd |-> ##5 (read_valid_out && dev_dq_oe)[*2])
        else $error("read burst not two beats");
    a_idle_drivers_off: assert property (k_true && !rd_cmd |-> ##5 !dev_dq_oe ##1 !dev_dq_oe)
        else $error("drivers on after nop or write");
    // The first edge after reset still sees the held-low clock, so it is skipped.
    a_kclk_toggles: assert property ($past(reset_n) |-> k_true != $past(k_true))
        else $error("input clock stalled");
    a_echo_delay: assert property (echo_clock_out == $past(k_true))
        else $error("echo clock wrong");
    a_valid_is_oe: assert property (read_valid_out == dev_dq_oe)
        else $error("valid does not match drive");
    // Valid may only stand in the two beat cycles that follow a read command.
    a_valid_after_read: assert property (read_valid_out |->
        $past(rd_cmd, 5) || $past(rd_cmd, 6))
        else $error("valid without a read beat");
    a_write_beats: assert property (wr_cmd |-> ##2 ctl_dq_oe[*2])
        else $error("write beats missing");
    a_bw_idle_high: assert property (!ctl_dq_oe |-> &byte_write_enables_n)
        else $error("byte enable low outside beats");
    a_no_drive_clash: assert property (!(ctl_dq_oe && dev_dq_oe))
        else $error("both ends drive data");
    c_read: cover property (rd_cmd);
    c_write: cover property (wr_cmd);
    c_read_pair: cover property (rd_cmd ##2 rd_cmd);
endmodule // sram_link_props

// >>> sram_pkg.sv
package sram_pkg;

    localparam int LANE_BITS = 9;
    localparam int WORD_BITS = 18;
    localparam int PAR_BITS = 5;
    localparam int CW_BITS = 23;

    // Link timing: one clk_sys cycle is one half of the input clock period.
    localparam int CLK_PERIOD_NS = 5;
    localparam int KSTOP_NS = 30;
    localparam int KSTOP_CYC = (KSTOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IMPED_KCYC = 163840;
    localparam int LOCK_KCYC = 65536;
    localparam int DLL_RESET_KCYC = 4;
    localparam int RD_SPACING_K = 2;

    // Device pipeline stages: stage s holds a command s+1 clk_sys cycles after its command cycle.
    localparam int PIPE_LEN = 6;
    localparam int ST_WR_BEAT1 = 1;
    localparam int ST_WR_BEAT2 = 2;
    localparam int ST_RD_FETCH = 3;
    localparam int ST_RD_BEAT2 = 4;

    typedef enum logic [1:0] {
        CMD_NONE = 2'h0,
        CMD_READ = 2'h1,
        CMD_WRITE = 2'h3
    } cmd_t;

    typedef enum logic [1:0] {
        PWR_IMPED = 2'h0,
        PWR_LOCK = 2'h1,
        PWR_RUN = 2'h3,
        PWR_DLL_RST = 2'h2
    } pwr_t;

    // Hamming layout: parity at positions 1, 2, 4, 8, 16; data fills the rest in order.
    function automatic logic [CW_BITS-1:0] ecc_encode(input logic [WORD_BITS-1:0] data);
        logic [CW_BITS-1:0] cw;
        int j;
        cw = '0;
        j = 0;
        for (int p = 1; p <= CW_BITS; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p - 1] = data[j];
                j++;
            end
        end
        for (int k = 0; k < PAR_BITS; k++) begin
            for (int p = 1; p <= CW_BITS; p++) begin
                if (((p >> k) & 1) == 1 && (p & (p - 1)) != 0) begin
                    cw[(1 << k) - 1] = cw[(1 << k) - 1] ^ cw[p - 1];
                end
            end
        end
        return cw;
    endfunction

    function automatic logic [PAR_BITS-1:0] ecc_syndrome(input logic [CW_BITS-1:0] cw);
        logic [PAR_BITS-1:0] syn;
        syn = '0;
        for (int p = 1; p <= CW_BITS; p++) begin
            if (cw[p - 1]) begin
                syn = syn ^ PAR_BITS'(p);
            end
        end
        return syn;
    endfunction

    function automatic logic [WORD_BITS-1:0] ecc_correct(input logic [CW_BITS-1:0] cw,
                                                        input logic enable);
        logic [CW_BITS-1:0] fixed;
        logic [PAR_BITS-1:0] syn;
        logic [WORD_BITS-1:0] data;
        int j;
        syn = ecc_syndrome(cw);
        fixed = cw;
        data = '0;
        j = 0;
        if (enable && syn != '0 && syn <= PAR_BITS'(CW_BITS)) begin
            fixed[syn - 5'h1] = ~fixed[syn - 5'h1];
        end
        for (int p = 1; p <= CW_BITS; p++) begin
            if ((p & (p - 1)) != 0) begin
                data[j] = fixed[p - 1];
                j++;
            end
        end
        return data;
    endfunction

endpackage
